// >>> rtc_port_pkg.sv
/*
  Shared constants and types for the timekeeping-domain indirect access port.
  Assumes a 32-bit APB register window and an 8-bit internal register space.
*/
package rtc_port_pkg;
  // byte addresses on APB
  localparam logic [11:0] KEY_OFS  = 12'h000;
  localparam logic [11:0] ADDR_OFS = 12'h004;
  localparam logic [11:0] DATA_OFS = 12'h008;
  // key codes
  localparam logic [7:0] KEY_FIRST  = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  // indirect address register fields
  localparam int BUSY_BIT  = 7;
  localparam int CHAIN_BIT = 6;
  localparam int FAST_BIT  = 4;
  localparam int IADDR_W   = 4;
  localparam logic FAST_RST  = 1'b1;
  localparam logic CHAIN_RST = 1'b0;
  // lock status codes read back from the key register
  localparam logic [7:0] STAT_LOCKED = 8'h00;
  localparam logic [7:0] STAT_FIRST  = 8'h01;
  localparam logic [7:0] STAT_OPEN   = 8'h02;
  localparam logic [7:0] STAT_DEAD   = 8'h03;
  // transfer length in system clock cycles
  localparam int SLOW_CYCLES = 7;
  localparam int FAST_CYCLES = 6;

  typedef enum logic [1:0] {LK_LOCKED, LK_FIRST, LK_OPEN, LK_DEAD} lock_state_e;

  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [IADDR_W-1:0] addr;
    logic [7:0]         wdata;
  } int_req_s;
endpackage : rtc_port_pkg

// >>> key_lock_fsm.sv
/*
  Lock and key state machine of the indirect access port.
  Assumes one-cycle write and violation strobes from the bus slave.
*/
`timescale 1ns/100ps
module key_lock_fsm (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      key_wr_i,
  input  wire logic [7:0]                key_data_i,
  input  wire logic                      violation_i,
  output rtc_port_pkg::lock_state_e      state_o
);
  rtc_port_pkg::lock_state_e next_state;

  always_comb begin
    next_state = state_o;
    case (state_o)
      rtc_port_pkg::LK_LOCKED: begin
        if (violation_i) next_state = rtc_port_pkg::LK_DEAD;
        else if (key_wr_i) begin
          next_state = (key_data_i == rtc_port_pkg::KEY_FIRST) ?
                       rtc_port_pkg::LK_FIRST : rtc_port_pkg::LK_DEAD;
        end
      end
      rtc_port_pkg::LK_FIRST: begin
        if (violation_i) next_state = rtc_port_pkg::LK_DEAD;
        else if (key_wr_i) begin
          next_state = (key_data_i == rtc_port_pkg::KEY_SECOND) ?
                       rtc_port_pkg::LK_OPEN : rtc_port_pkg::LK_DEAD;
        end
      end
      rtc_port_pkg::LK_OPEN: begin
        if (key_wr_i) next_state = rtc_port_pkg::LK_LOCKED;
      end
      default: next_state = rtc_port_pkg::LK_DEAD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) state_o <= rtc_port_pkg::LK_LOCKED;
    else state_o <= next_state;
  end
endmodule : key_lock_fsm

// >>> strobe_timer.sv
/*
  Fixed-length transfer timer: busy for slow or fast cycle count after start.
  Assumes start only arrives while idle.
*/
`timescale 1ns/100ps
module strobe_timer #(
  parameter int SLOW = rtc_port_pkg::SLOW_CYCLES,
  parameter int FAST = rtc_port_pkg::FAST_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic fast_i,
  output logic      busy_o,
  output logic      done_o
);
  initial begin
    if (FAST < 2 || SLOW < FAST || SLOW > 15) $error("strobe_timer: bad lengths");
  end

  logic [3:0] count;
  logic [3:0] last;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      count  <= 4'h0;
      last   <= 4'h0;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      count  <= 4'h0;
      last   <= fast_i ? 4'(FAST - 1) : 4'(SLOW - 1);
    end else if (busy_o) begin
      count <= count + 4'h1;
      if (count == last) busy_o <= 1'b0;
    end
  end

  assign done_o = busy_o && (count == last);
endmodule : strobe_timer

// >>> rtc_indirect_access_port.sv
/*
  Key-protected indirect access port from APB to the timekeeping domain's
  internal byte registers. Assumes the internal register file answers a read
  strobe combinationally on int_rdata_i in the same cycle.
*/
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
// Function
// RULE1 - keys A5 then F1 unlock, no timing
// RULE2 - bad key or locked access disables port
// RULE3 - unlimited accesses while unlocked
// RULE4 - key write while unlocked relocks
// RULE5 - key read shows status, harmless
// RULE6 - internal registers only reached indirectly
// RULE7 - address register selects target register
// RULE8 - data write starts indirect write
// RULE9 - busy write starts read into data
// RULE10 - processor polls busy before accesses
// RULE11 - address and data survive reset
// RULE12 - seven cycles, six with fast strobe
// RULE13 - fast strobe on after reset, switchable
// RULE14 - chained: data read starts next read
// RULE15 - processor sets busy once per chain
// RULE16 - chain bit in address register enables
// RULE17 - address steps after snapshot/alarm byte
// RULE18 - busy high until transfer done
module rtc_indirect_access_port #(
  parameter logic [3:0] SNAP_BASE  = 4'h0,
  parameter logic [3:0] ALARM_BASE = 4'h8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  output rtc_port_pkg::int_req_s     int_req_o,
  input  wire logic [7:0]            int_rdata_i
);
  initial begin
    if (SNAP_BASE[1:0] != 2'b00 || ALARM_BASE[1:0] != 2'b00) $error("bases not aligned");
  end

  logic                      wr_en;
  logic                      rd_en;
  logic                      setup;
  logic                      is_key;
  logic                      is_addr;
  logic                      is_data;
  logic                      open;
  logic                      violation;
  logic                      busy;
  logic                      done;
  logic                      start_rd;
  logic                      start_wr;
  logic                      chain_rd;
  logic                      op_read;
  logic                      in_range;
  logic                      fast_en;
  logic                      chain_en;
  logic [3:0]                iaddr;
  logic [7:0]                data_reg;
  logic [7:0]                key_stat;
  rtc_port_pkg::lock_state_e key_st;

  assign setup   = psel_i && !penable_i;
  assign wr_en   = psel_i && penable_i && pwrite_i;
  assign rd_en   = psel_i && penable_i && !pwrite_i;
  assign is_key  = paddr_i == rtc_port_pkg::KEY_OFS;
  assign is_addr = paddr_i == rtc_port_pkg::ADDR_OFS;
  assign is_data = paddr_i == rtc_port_pkg::DATA_OFS;
  assign open    = key_st == rtc_port_pkg::LK_OPEN;

  // zero wait states; only three words are decoded
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !(is_key || is_addr || is_data); // see RULE6

  // any touch of address or data while not open kills the port
  assign violation = (wr_en || rd_en) && (is_addr || is_data) && !open; // see RULE2

  key_lock_fsm u_lock (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .key_wr_i   (wr_en && is_key), // see RULE1 see RULE4
    .key_data_i (pwdata_i[7:0]),
    .violation_i(violation),
    .state_o    (key_st)
  );

  // requests while busy are dropped; firmware is expected to poll first
  assign start_rd = wr_en && is_addr && open && !busy && pwdata_i[rtc_port_pkg::BUSY_BIT]; // see RULE9
  assign start_wr = wr_en && is_data && open && !busy; // see RULE8 see RULE3
  assign chain_rd = rd_en && is_data && open && !busy && chain_en; // see RULE14

  strobe_timer u_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .start_i(start_rd || start_wr || chain_rd),
    .fast_i (fast_en), // see RULE12
    .busy_o (busy),    // see RULE18
    .done_o (done)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) op_read <= 1'b0;
    else if (start_rd || chain_rd) op_read <= 1'b1;
    else if (start_wr) op_read <= 1'b0;
  end

  // control bits of the address register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_en  <= rtc_port_pkg::FAST_RST; // see RULE13
      chain_en <= rtc_port_pkg::CHAIN_RST;
    end else if (wr_en && is_addr && open && !busy) begin
      fast_en  <= pwdata_i[rtc_port_pkg::FAST_BIT];  // see RULE13
      chain_en <= pwdata_i[rtc_port_pkg::CHAIN_BIT]; // see RULE16
    end
  end

  assign in_range = (iaddr[3:2] == SNAP_BASE[3:2]) || (iaddr[3:2] == ALARM_BASE[3:2]);

  // no reset on purpose: the selection survives a device reset
  always_ff @(posedge clk_i) begin
    if (!rst_i && wr_en && is_addr && open && !busy) begin
      iaddr <= pwdata_i[3:0]; // see RULE7 see RULE11
    end else if (!rst_i && done && in_range) begin
      iaddr <= iaddr + 4'h1; // see RULE17
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_i && start_wr) begin
      data_reg <= pwdata_i[7:0]; // see RULE11
    end else if (!rst_i && done && op_read) begin
      data_reg <= int_rdata_i; // see RULE9
    end
  end

  // strobes fire in the last busy cycle, address and data from registers
  assign int_req_o.wr    = done && !op_read; // see RULE8
  assign int_req_o.rd    = done && op_read;  // see RULE9
  assign int_req_o.addr  = iaddr;            // see RULE7
  assign int_req_o.wdata = data_reg;

  always_comb begin
    case (key_st)
      rtc_port_pkg::LK_LOCKED: key_stat = rtc_port_pkg::STAT_LOCKED;
      rtc_port_pkg::LK_FIRST:  key_stat = rtc_port_pkg::STAT_FIRST;
      rtc_port_pkg::LK_OPEN:   key_stat = rtc_port_pkg::STAT_OPEN;
      default:                 key_stat = rtc_port_pkg::STAT_DEAD;
    endcase
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup && !pwrite_i) begin
      if (is_key) begin
        prdata_o <= {24'h00_0000, key_stat}; // see RULE5
      end else if (is_addr && open) begin
        prdata_o <= {24'h00_0000, busy, chain_en, 1'b0, fast_en, iaddr}; // see RULE18
      end else if (is_data && open) begin
        prdata_o <= {24'h00_0000, data_reg};
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  property p_unlock;
    @(posedge clk_i) disable iff (rst_i)
    key_st == rtc_port_pkg::LK_FIRST && wr_en && is_key && pwdata_i[7:0] == 8'hF1
    |=> key_st == rtc_port_pkg::LK_OPEN;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock failed"); // see RULE1

  property p_violation;
    @(posedge clk_i) disable iff (rst_i)
    violation |=> key_st == rtc_port_pkg::LK_DEAD ##1 key_st == rtc_port_pkg::LK_DEAD;
  endproperty
  a_violation: assert property (p_violation) else $error("port not disabled"); // see RULE2

  property p_relock;
    @(posedge clk_i) disable iff (rst_i)
    open && wr_en && is_key |=> key_st == rtc_port_pkg::LK_LOCKED;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock"); // see RULE4

  property p_key_read;
    @(posedge clk_i) disable iff (rst_i)
    rd_en && is_key |=> key_st == $past(key_st);
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read disturbed"); // see RULE5

  property p_fast_len;
    @(posedge clk_i) disable iff (rst_i)
    (start_rd || start_wr || chain_rd) && fast_en |=> busy [*6] ##1 !busy;
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast length wrong"); // see RULE12

  property p_slow_len;
    @(posedge clk_i) disable iff (rst_i)
    (start_rd || start_wr) && !fast_en |=> busy [*7] ##1 !busy;
  endproperty
  a_slow_len: assert property (p_slow_len) else $error("slow length wrong"); // see RULE18

  property p_write_xfer;
    @(posedge clk_i) disable iff (rst_i)
    start_wr |-> ##[6:7] (int_req_o.wr && int_req_o.wdata == $past(pwdata_i[7:0], 6));
  endproperty
  a_write_xfer: assert property (p_write_xfer) else $error("write lost"); // see RULE8

  property p_read_copy;
    @(posedge clk_i) disable iff (rst_i)
    int_req_o.rd |=> data_reg == $past(int_rdata_i);
  endproperty
  a_read_copy: assert property (p_read_copy) else $error("read not copied"); // see RULE9

  property p_step;
    @(posedge clk_i) disable iff (rst_i)
    done && in_range |=> iaddr == $past(iaddr) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("address did not step"); // see RULE17

  property p_chain;
    @(posedge clk_i) disable iff (rst_i)
    rd_en && is_data && open && !busy && chain_en |=> busy && op_read;
  endproperty
  a_chain: assert property (p_chain) else $error("chained read missing"); // see RULE14

  property p_fast_reset;
    @(posedge clk_i) rst_i |=> fast_en;
  endproperty
  a_fast_reset: assert property (p_fast_reset) else $error("fast strobe off"); // see RULE13

  property p_unmapped;
    @(posedge clk_i) disable iff (rst_i)
    pslverr_o |=> key_st == $past(key_st);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("lock moved"); // see RULE6

  property p_dead_stays;
    @(posedge clk_i) disable iff (rst_i)
    key_st == rtc_port_pkg::LK_DEAD |=> key_st == rtc_port_pkg::LK_DEAD;
  endproperty
  a_dead_stays: assert property (p_dead_stays) else $error("port revived"); // see RULE2

  property p_open_stays;
    @(posedge clk_i) disable iff (rst_i)
    open && !(wr_en && is_key) |=> open;
  endproperty
  a_open_stays: assert property (p_open_stays) else $error("port closed itself"); // see RULE3

  property p_busy_clear;
    @(posedge clk_i) disable iff (rst_i)
    done |=> !busy;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy stuck"); // see RULE18

  property p_rd_strobe;
    @(posedge clk_i) disable iff (rst_i)
    (start_rd || chain_rd) |-> ##[6:7] int_req_o.rd;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing"); // see RULE9

  // reads are checked in the access phase, where firmware takes them
  property p_stat_open;
    @(posedge clk_i) disable iff (rst_i)
    rd_en && is_key && open |-> prdata_o == {24'h00_0000, rtc_port_pkg::STAT_OPEN};
  endproperty
  a_stat_open: assert property (p_stat_open) else $error("bad status"); // see RULE5

  property p_locked_zero;
    @(posedge clk_i) disable iff (rst_i)
    rd_en && (is_addr || is_data) && !open |-> prdata_o == 32'h0000_0000;
  endproperty
  a_locked_zero: assert property (p_locked_zero) else $error("locked read leaked"); // see RULE2

  property p_chain_off;
    @(posedge clk_i) disable iff (rst_i)
    rd_en && is_data && open && !busy && !chain_en |=> !busy;
  endproperty
  a_chain_off: assert property (p_chain_off) else $error("read started unchained"); // see RULE16

  property p_locked_idle;
    @(posedge clk_i) disable iff (rst_i)
    !open && !busy |=> !busy;
  endproperty
  a_locked_idle: assert property (p_locked_idle) else $error("transfer while locked"); // see RULE2

  c_unlock: cover property (@(posedge clk_i) disable iff (rst_i) $rose(open));
  c_read: cover property (@(posedge clk_i) disable iff (rst_i) int_req_o.rd);
  c_write: cover property (@(posedge clk_i) disable iff (rst_i) int_req_o.wr && in_range);
  c_chain: cover property (@(posedge clk_i) disable iff (rst_i) chain_rd);
endmodule : rtc_indirect_access_port

// >>> rtc_regfile_model.sv
/*
  Behavioural model of the timekeeping domain's internal byte registers.
  Assumes one-cycle wr/rd strobes and a combinational read answer.
*/
`timescale 1ns/100ps
module rtc_regfile_model (
  input  wire logic                    clk_i,
  input  wire rtc_port_pkg::int_req_s  req_i,
  output logic [7:0]                   rdata_o
);
  logic [7:0] mem [16];

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'(i) ^ 8'h5A;
  end

  always @(posedge clk_i) begin
    if (req_i.wr) mem[req_i.addr] <= req_i.wdata;
  end

  // inverted value outside a read strobe, so a late capture shows up
  assign rdata_o = req_i.rd ? mem[req_i.addr] : ~mem[req_i.addr];
endmodule : rtc_regfile_model

// >>> tb_rtc_indirect_access_port.sv
/*
  Self-checking bench for the indirect access port, APB master tasks.
  Assumes the register file model above on the internal side.
*/
`timescale 1ns/100ps
module tb_rtc_indirect_access_port;
  logic                   clk_i;
  logic                   rst_i;
  logic                   psel, penable, pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata_o, q;
  logic                   pready_o, pslverr_o, err;
  logic [7:0]             int_rdata;
  rtc_port_pkg::int_req_s int_req;
  int                     n_errors, checks, n;

  rtc_indirect_access_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .int_req_o(int_req), .int_rdata_i(int_rdata));
  rtc_regfile_model u_regs (.clk_i(clk_i), .req_i(int_req), .rdata_o(int_rdata));

  always #2 clk_i = ~clk_i;

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    q = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      wrap_up();
    end
  endtask : apb

  // cycles from the access edge to the internal strobe
  task automatic lat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (int_req.wr !== 1'b1 && int_req.rd !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      wrap_up();
    end
  endtask : lat

  // polling busy keeps the processor's side of the handshake
  task automatic idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, rtc_port_pkg::ADDR_OFS, 32'h0);
      k++;
    end while (q[rtc_port_pkg::BUSY_BIT] !== 1'b0 && k < 20);
    if (k >= 20) begin
      n_errors++;
      wrap_up();
    end
  endtask : idle

  function automatic logic [31:0] av(logic b, logic c, logic f, logic [3:0] a);
    return {24'h0, b, c, 1'b0, f, a};
  endfunction : av

  task automatic unlock;
    apb(1'b1, rtc_port_pkg::KEY_OFS, {24'h0, rtc_port_pkg::KEY_FIRST});
    apb(1'b1, rtc_port_pkg::KEY_OFS, {24'h0, rtc_port_pkg::KEY_SECOND});
  endtask : unlock

  initial begin
    clk_i = 1'b0; rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; n_errors = 0; checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, rtc_port_pkg::KEY_OFS, 32'h0);
    chk(q, {24'h0, rtc_port_pkg::STAT_LOCKED});
    apb(1'b1, rtc_port_pkg::KEY_OFS, {24'h0, rtc_port_pkg::KEY_FIRST});
    apb(1'b0, rtc_port_pkg::KEY_OFS, 32'h0);
    chk(q, {24'h0, rtc_port_pkg::STAT_FIRST});
    apb(1'b1, rtc_port_pkg::KEY_OFS, {24'h0, rtc_port_pkg::KEY_SECOND});
    apb(1'b0, rtc_port_pkg::KEY_OFS, 32'h0);
    chk(q, {24'h0, rtc_port_pkg::STAT_OPEN});
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, rtc_port_pkg::ADDR_OFS, av(1'b0, 1'b0, 1'b1, 4'h4));
    apb(1'b1, rtc_port_pkg::DATA_OFS, 32'h3C);
    lat();
    chk(32'(n), 32'(rtc_port_pkg::FAST_CYCLES));
    @(posedge clk_i);
    chk({24'h0, u_regs.mem[4]}, 32'h3C);
    apb(1'b1, rtc_port_pkg::ADDR_OFS, av(1'b1, 1'b0, 1'b1, 4'h4));
    apb(1'b0, rtc_port_pkg::ADDR_OFS, 32'h0);
    chk({31'h0, q[rtc_port_pkg::BUSY_BIT]}, 32'h1);
    idle();
    apb(1'b0, rtc_port_pkg::DATA_OFS, 32'h0);
    chk(q, 32'h3C);
    apb(1'b1, rtc_port_pkg::ADDR_OFS, av(1'b0, 1'b0, 1'b0, 4'h5));
    apb(1'b1, rtc_port_pkg::DATA_OFS, 32'h77);
    lat();
    chk(32'(n), 32'(rtc_port_pkg::SLOW_CYCLES));
    idle();
    apb(1'b1, rtc_port_pkg::ADDR_OFS, av(1'b0, 1'b0, 1'b1, 4'h8));
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, rtc_port_pkg::DATA_OFS, 32'(8'h11 * (i + 1)));
      idle();
      chk({24'h0, u_regs.mem[8 + i]}, 32'(8'h11 * (i + 1)));
    end
    chk({28'h0, q[3:0]}, 32'hC);
    apb(1'b1, rtc_port_pkg::ADDR_OFS, av(1'b1, 1'b1, 1'b1, 4'h8));
    idle();
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, rtc_port_pkg::DATA_OFS, 32'h0);
      chk(q, 32'(8'h11 * (i + 1)));
      idle();
    end
    apb(1'b1, rtc_port_pkg::KEY_OFS, 32'h0);
    apb(1'b0, rtc_port_pkg::KEY_OFS, 32'h0);
    chk(q, {24'h0, rtc_port_pkg::STAT_LOCKED});
    apb(1'b0, rtc_port_pkg::DATA_OFS, 32'h0);
    chk(q, 32'h0);
    unlock();
    apb(1'b0, rtc_port_pkg::KEY_OFS, 32'h0);
    chk(q, {24'h0, rtc_port_pkg::STAT_DEAD});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    unlock();
    apb(1'b0, rtc_port_pkg::KEY_OFS, 32'h0);
    chk(q, {24'h0, rtc_port_pkg::STAT_OPEN});
    apb(1'b0, rtc_port_pkg::DATA_OFS, 32'h0);
    chk(q, 32'h44);
    apb(1'b0, rtc_port_pkg::ADDR_OFS, 32'h0);
    chk({25'h0, q[7:6], q[4:0]}, 32'h1C);
    wrap_up();
  end
endmodule : tb_rtc_indirect_access_port
